//--- tb/gsp_alt_model.sv
module gsp_alt_model (
    input wire logic clk, // control clock
    input wire logic slow, // crawl toward target
    input wire logic [15:0] freqSet, // target speed
    input wire logic [15:0] excSet, // target excitation
    input wire logic phaseFed, // fed from regulated phase
    input wire logic [15:0] vout, // regulated voltage
    input wire logic [15:0] vaux, // auxiliary voltage
    output logic [15:0] freqMeas, // measured speed
    output logic [15:0] excMeas, // measured excitation
    output logic [15:0] supplyRatio // ratio word to program
);
    timeunit 1ns;
    timeprecision 1ps;
    // a real rotor cannot jump speed, so slow mode slews
    always @(posedge clk) begin
        excMeas <= excSet;
        if (!slow || freqMeas == freqSet) begin
            freqMeas <= freqSet;
        end else if (freqMeas < freqSet) begin
            freqMeas <= freqMeas + 16'h0001;
        end else begin
            freqMeas <= freqMeas - 16'h0001;
        end
    end
    // zero on phase feed, else scaled excess of vout over vaux
    assign supplyRatio = phaseFed ? 16'h0000 :
        16'((32'h0000_7FFF * vout) / vaux - 32'h0000_7FFF);
endmodule // gsp_alt_model

//--- tb/gsp_speed_prot_checker.sv
module gsp_speed_prot_checker #(
    parameter int TENTH_CYCLES = 20 // one tenth in clocks
) (
    input wire logic clk, // control clock
    input wire logic nrst, // sync reset, low
    input wire logic hsel, // slave select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // slave response
    input wire logic [31:0] hrdata, // read data
    input wire logic [15:0] nominalSet, // nominal setpoint
    input wire logic shortCircuit, // short present
    input wire logic [15:0] setpointOut, // regulated setpoint
    input wire logic alarmOutput, // alarm relay
    input wire logic blocked, // regulator blocked
    input wire logic [3:0] flashCode // indicator pattern
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // zero wait states, never an error
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
    // read data only moves when a read is taken
    rdata_hold_a: assert property (
        !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    // blocking is sticky until reset
    block_sticky_a: assert property (blocked |=> blocked)
        else $error("blocked state released");
    // blocking needs a short behind it
    block_cause_a: assert property ($rose(blocked) |->
        $past(shortCircuit) || $past(shortCircuit, 2))
        else $error("blocked without short");
    // reduction never lifts above nominal
    setpt_bound_a: assert property (
        $changed(setpointOut) |-> setpointOut <= nominalSet)
        else $error("setpoint above nominal");
    // setpoint holds for 8 clocks after each move
    setpt_tick_a: assert property (
        $changed(setpointOut) |=> $stable(setpointOut)[*8])
        else $error("setpoint moved twice in a tick");
    // only alarm numbers we implement may show
    flash_legal_a: assert property (
        flashCode inside {4'h0, 4'h4, 4'h6, 4'h7, 4'h8})
        else $error("illegal flash code");
    // the relay only closes while some alarm is shown
    alarm_out_a: assert property (
        alarmOutput |-> flashCode != 4'h0)
        else $error("relay on with no alarm shown");
endmodule // gsp_speed_prot_checker

bind gsp_speed_prot gsp_speed_prot_checker #(
    .TENTH_CYCLES(TENTH_CYCLES)
) i_gsp_speed_prot_checker (.clk(clk), .nrst(nrst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .nominalSet(nominalSet), .shortCircuit(shortCircuit),
    .setpointOut(setpointOut), .alarmOutput(alarmOutput),
    .blocked(blocked), .flashCode(flashCode));

//--- tb/tb.sv
`include "gsp_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] ctrl; // mode bits
        logic jmp; // jumper pin
        logic [14:0] us; // underspeed word
        logic [15:0] os; // overspeed word
        logic [31:0] trips; // expected trip points
    } gsp_row_t;
    logic clk, nrst, hsel, hwrite, jumper60, shortCircuit, slow, phaseFed;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rv;
    logic hreadyout, hresp, alarmOutput, blocked;
    logic [15:0] freqMeas, excMeas, supplyRatio, setpointOut, nominalSet;
    logic [15:0] freqSet, excSet, vout, vaux;
    logic [14:0] trimmerPos;
    logic [3:0] flashCode;
    int n_fail, tests_run;
    // trip table, centihertz {over, under}
    gsp_row_t rows [8] = '{
        '{16'hFF00, 1'b0, 15'h0000, 16'h0000, 32'h157C_0FA0},
        '{16'hFF00, 1'b0, 15'h4000, 16'h7FFF, 32'h1770_1194},
        '{16'hFF00, 1'b0, 15'h7FFF, 16'h8001, 32'h1388_1388},
        '{16'hFF02, 1'b0, 15'h4000, 16'h0000, 32'h19C8_1518},
        '{16'hFF01, 1'b1, 15'h0000, 16'h7FFF, 32'h1C20_12C0},
        '{16'hFF00, 1'b1, 15'h7FFF, 16'h8001, 32'h1388_1388},
        '{16'hFF01, 1'b1, 15'h7FFF, 16'h8001, 32'h1770_1770},
        '{16'hFF00, 1'b0, 15'h2000, 16'hFFFF, 32'h157C_109A}};
    logic [15:0] excV [4] = '{16'h03FF, 16'h0400, 16'h7000, 16'h7001};
    logic [31:0] excA [4] = '{32'h80, 32'h800, 32'h800, 32'h80};

    gsp_speed_prot #(.TENTH_CYCLES(20)) i_gsp_speed_prot (.clk(clk),
        .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .freqMeas(freqMeas), .jumper60(jumper60),
        .trimmerPos(trimmerPos), .nominalSet(nominalSet),
        .excMeas(excMeas), .shortCircuit(shortCircuit),
        .setpointOut(setpointOut), .alarmOutput(alarmOutput),
        .blocked(blocked), .flashCode(flashCode));
    gsp_alt_model i_gsp_alt_model (.clk(clk), .slow(slow),
        .freqSet(freqSet), .excSet(excSet), .phaseFed(phaseFed),
        .vout(vout), .vaux(vaux), .freqMeas(freqMeas),
        .excMeas(excMeas), .supplyRatio(supplyRatio));

    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    // one single transfer, address phase then data phase
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rv = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rv, e); // compare read word
    endtask
    // control ticks fall every 250 clocks
    task automatic ticks(input int n);
        repeat (n * 250 + 5) @(posedge clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, well above the planned run
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        n_fail = 0;
        tests_run = 0;
        {hsel, hwrite, jumper60, shortCircuit, slow} <= 5'h00;
        {haddr, htrans, hwdata} <= 42'h0;
        hsize <= 3'b010;
        trimmerPos <= 15'h1234;
        nominalSet <= 16'h2710;
        excSet <= 16'h1000;
        freqSet <= 16'h0FA0;
        phaseFed <= 1'b1;
        vout <= 16'h0002;
        vaux <= 16'h0001;
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(`GSP_OFS_CTRL, 32'h0000_FF00);
        rdc(`GSP_OFS_USTHR, 32'h0000_4000);
        rdc(`GSP_OFS_SLWORK, 32'h0000_2328);
        rdc(`GSP_OFS_SLSTART, 32'h0000_1770);
        rdc(`GSP_OFS_ALARM, 32'h0000_0800);
        rdc(8'h40, 32'h0000_0000);
        done("reset");
        ticks(2);
        chk(32'(setpointOut), 32'h0000_2551);
        rdc(`GSP_OFS_ALARM, 32'h0000_0020);
        chk(32'(flashCode), 32'h0000_0006);
        chk(32'(alarmOutput), 32'h0000_0001);
        freqSet <= 16'h1388;
        ticks(2);
        chk(32'(setpointOut), 32'h0000_2710);
        rdc(`GSP_OFS_ALARM, 32'h0000_0800);
        chk(32'(flashCode), 32'h0000_0000);
        freqSet <= 16'h0FA0;
        ticks(2);
        chk(32'(setpointOut), 32'h0000_2472);
        bus(1'b1, `GSP_OFS_CTRL, 32'h0000_0000);
        ticks(1);
        chk(32'(alarmOutput), 32'h0000_0000);
        chk(32'(flashCode), 32'h0000_0006);
        done("slopes");
        bus(1'b1, `GSP_OFS_CTRL, 32'h0000_FF04);
        ticks(1);
        rdc(`GSP_OFS_USEFF, 32'h0000_1234);
        bus(1'b1, `GSP_OFS_SLWORK, 32'h0000_0000);
        rdc(`GSP_OFS_CTRL, 32'h0000_FF00);
        ticks(2);
        chk(32'(setpointOut), 32'h0000_2710);
        done("trimmer");
        bus(1'b1, `GSP_OFS_SLWORK, 32'h0000_7FFF);
        slow <= 1'b1;
        freqSet <= 16'h0000;
        ticks(18);
        chk(32'(setpointOut), 32'h0000_09C3);
        phaseFed <= 1'b0;
        @(posedge clk);
        bus(1'b1, `GSP_OFS_RATIO, 32'(supplyRatio));
        ticks(2);
        chk(32'(setpointOut), 32'h0000_1387);
        bus(1'b1, `GSP_OFS_RATIO, 32'h0000_0000);
        slow <= 1'b0;
        freqSet <= 16'h1388;
        done("floor");
        foreach (rows[i]) begin
            jumper60 <= rows[i].jmp;
            bus(1'b1, `GSP_OFS_CTRL, 32'(rows[i].ctrl));
            bus(1'b1, `GSP_OFS_USTHR, 32'(rows[i].us));
            bus(1'b1, `GSP_OFS_OSTHR, 32'(rows[i].os));
            ticks(2);
            rdc(`GSP_OFS_TRIPS, rows[i].trips);
        end
        done("trip table");
        for (int i = 0; i < 4; i++) begin
            excSet <= excV[i];
            ticks(2);
            rdc(`GSP_OFS_ALARM, excA[i]);
            chk(32'(setpointOut), 32'h0000_2710);
        end
        excSet <= 16'h1000;
        freqSet <= 16'h15E0;
        ticks(2);
        rdc(`GSP_OFS_ALARM, 32'h0000_0040);
        chk(32'(flashCode), 32'h0000_0007);
        freqSet <= 16'h1388;
        done("window and overspeed");
        shortCircuit <= 1'b1;
        repeat (300) @(posedge clk);
        chk(32'(blocked), 32'h0000_0000);
        shortCircuit <= 1'b0;
        bus(1'b1, `GSP_OFS_SCTIME, 32'h0000_0005);
        shortCircuit <= 1'b1;
        repeat (70) @(posedge clk);
        chk(32'(blocked), 32'h0000_0000);
        repeat (60) @(posedge clk);
        chk(32'(blocked), 32'h0000_0001);
        shortCircuit <= 1'b0;
        repeat (10) @(posedge clk);
        chk(32'(blocked), 32'h0000_0001);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        chk(32'(blocked), 32'h0000_0000);
        done("short circuit");
        tally_and_finish();
    end
endmodule // tb

//--- verilog/gsp_params.svh
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH

// register byte offsets
`define GSP_OFS_CTRL 8'h00
`define GSP_OFS_USTHR 8'h04
`define GSP_OFS_SLWORK 8'h08
`define GSP_OFS_SLSTART 8'h0C
`define GSP_OFS_OSTHR 8'h10
`define GSP_OFS_RATIO 8'h14
`define GSP_OFS_SCTIME 8'h18
`define GSP_OFS_EXCLO 8'h1C
`define GSP_OFS_USEFF 8'h20
`define GSP_OFS_ALARM 8'h24
`define GSP_OFS_SETPT 8'h28
`define GSP_OFS_TRIPS 8'h2C

// control register fields
`define GSP_CTRL_JMPEN 0
`define GSP_CTRL_FLAG60 1
`define GSP_CTRL_TRIMEN 2
`define GSP_CTRL_MASK_LSB 8
`define GSP_CTRL_RST 16'hFF00

// reset values of parameter words
`define GSP_USTHR_RST 15'h4000
`define GSP_SLWORK_RST 15'h2328
`define GSP_SLSTART_RST 15'h1770
`define GSP_OSTHR_RST 16'h0000
`define GSP_RATIO_RST 16'h0000
`define GSP_SCTIME_RST 8'h00
`define GSP_EXCLO_RST 16'h0400

// frequency points in centihertz, 50 Hz scale
`define GSP_US_LO 32'h0000_0FA0
`define GSP_US_MID 32'h0000_1194
`define GSP_SPAN 32'h0000_01F4
`define GSP_OS_MID 32'h0000_157C
`define GSP_HALF 32'h0000_4000
`define GSP_HALF_M1 32'h0000_3FFF
`define GSP_FULL 32'h0000_7FFF

// voltage math
`define GSP_VF_SHIFT 26
`define GSP_MIN_FRAC 48'h0000_0000_2000
`define GSP_EXC_UPPER 16'h7000

// alarm word bits (alarm n at bit n-1)
`define GSP_AL_SHORT 3
`define GSP_AL_UNDERSPD 5
`define GSP_AL_OVERSPD 6
`define GSP_AL_UNDEREXC 7
`define GSP_AL_OK 11

// timing
`define GSP_CLK_PERIOD_NS 4
`define GSP_CTRL_PERIOD_NS 1000
`define GSP_CTRL_CYCLES (`GSP_CTRL_PERIOD_NS / `GSP_CLK_PERIOD_NS)
`define GSP_TENTH_MS 100
`define GSP_TENTH_CYCLES (`GSP_TENTH_MS * 1000000 / `GSP_CLK_PERIOD_NS)

`endif

//--- verilog/gsp_pkg.sv
package gsp_pkg;

    // slope phase: start-up ramp until first pass over trip point
    typedef enum logic [1:0] {
        GSP_START = 2'b01,
        GSP_RUN = 2'b10
    } gsp_phase_t;

endpackage

//--- verilog/gsp_speed_prot.sv
// Summary of operation
// - below trip, setpoint falls with frequency
// - trip from jumper, flag, trimmer, parameter
// - volts-per-hertz active raises alarm 6, flash
// - parameter 16384 trips at 45/54 Hz
// - 60 Hz if enabled jumper or flag
// - 0..16384 moves trip from 40/48 Hz
// - 16384..32767 raises trip to 50/60 Hz
// - working slope resets 9000, zero no cut
// - effective trimmer threshold readable as status
// - threshold or working slope write disables trimmer
// - above trip restore setpoint, drop alarm 6
// - overspeed zero trips at 55/66 Hz
// - negative overspeed lowers trip to 50/60
// - positive overspeed raises trip to 60/72
// - reduction floored to keep supply sufficient
// - supply ratio word sets the floor
// - start slope 6000 until first over trip
// - short circuit timer tenths then block
// - excitation outside window raises alarm 8
// - upper excitation limit fixed, lower set
// - underexcitation only signals, never regulates
// - alarm word bit n-1, bit 11 ok
`include "gsp_params.svh"

module gsp_speed_prot #(
    parameter int TENTH_CYCLES = `GSP_TENTH_CYCLES // 0.1 s in clocks
) (
    input wire logic clk, // 250 MHz clock
    input wire logic nrst, // sync reset, low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [15:0] freqMeas, // centihertz
    input wire logic jumper60, // 60 Hz jumper fitted
    input wire logic [14:0] trimmerPos, // speed trimmer
    input wire logic [15:0] nominalSet, // nominal setpoint
    input wire logic [15:0] excMeas, // excitation measure
    input wire logic shortCircuit, // short detected
    output logic [15:0] setpointOut, // to voltage loop
    output logic alarmOutput, // alarm output relay
    output logic blocked, // regulator blocked
    output logic [3:0] flashCode // indicator pattern
);

    // all points are centihertz on the 50 Hz scale; the
    // 60 Hz scale is applied once, afterwards, so the two
    // modes share one interpolation. the lower span is a
    // power of two, so a shift stands in for the divide.
    // integer interpolation of the underspeed trip, 50 Hz scale
    function automatic logic [15:0] usTrip50(
        input logic [14:0] p
    );
        logic [31:0] t;
        t = 32'(p);
        if (t <= `GSP_HALF) begin
            usTrip50 = 16'(`GSP_US_LO + ((t * `GSP_SPAN) >> 14));
        end else begin
            usTrip50 = 16'(`GSP_US_MID
                + ((t - `GSP_HALF) * `GSP_SPAN) / `GSP_HALF_M1);
        end
    endfunction

    // division truncates toward zero, so a word of -1 still
    // trips at the nominal overspeed point.
    // signed overspeed trip, one line through 55 Hz
    function automatic logic [15:0] osTrip50(
        input logic [15:0] p
    );
        logic signed [31:0] t;
        t = 32'(signed'(p)) * signed'(`GSP_SPAN);
        t = t / signed'(`GSP_FULL);
        osTrip50 = 16'(signed'(`GSP_OS_MID) + t);
    endfunction

    // six fifths in integers: every end point is a multiple
    // of five centihertz, so none of them is rounded.
    // 60 Hz points are the 50 Hz points times six fifths
    function automatic logic [15:0] modeScale(
        input logic [15:0] f,
        input logic m60
    );
        logic [31:0] t;
        t = (32'(f) * 32'h0000_0006) / 32'h0000_0005;
        modeScale = m60 ? 16'(t) : f;
    endfunction

    // parameter words change only by a whole-word write, so
    // a tick never sees half of a new value.
    // configuration and status registers
    logic [15:0] ctrl_ff; // mode bits and alarm mask
    logic [14:0] usThr_ff; // underspeed parameter
    logic [14:0] slWork_ff; // working slope
    logic [14:0] slStart_ff; // start-up slope
    logic [15:0] osThr_ff; // overspeed parameter, signed
    logic [15:0] ratio_ff; // supply ratio word
    logic [7:0] scTime_ff; // short timer, tenths
    logic [15:0] excLo_ff; // excitation lower limit
    logic [14:0] usEff_ff; // published threshold
    logic [15:0] usTripR_ff; // latched trip, underspeed
    logic [15:0] osTripR_ff; // latched trip, overspeed
    logic [15:0] alarm_ff; // alarm word
    gsp_pkg::gsp_phase_t phase_ff; // slope phase
    gsp_pkg::gsp_phase_t nxt_phase;

    // no wait states: the data phase is always the cycle
    // right after its address phase.
    // bus data-phase state
    logic wrPend_ff; // write in data phase
    logic [7:0] wrAddr_ff; // its address
    logic [31:0] rdata_ff; // read data register

    // the short timer counts raw clocks, so its resolution
    // does not depend on the control tick period.
    // control-cycle divider and short timer
    logic [11:0] tickCnt_ff; // control cycle divider
    logic [31:0] tenthCnt_ff; // clocks in a tenth
    logic [7:0] tenths_ff; // tenths under short
    logic blocked_ff; // sticky block
    logic [15:0] setpt_ff; // setpoint register
    logic apo_ff; // alarm output register
    logic [3:0] flash_ff; // indicator pattern reg

    // hready gates the accept so that a transfer stalled by
    // another slave is not taken twice.
    // address phase decode
    wire addrPhase = hsel & htrans[1] & hready;
    wire rdAccept = addrPhase & ~hwrite;
    wire wrAccept = addrPhase & hwrite;
    wire tick = (tickCnt_ff == 12'(`GSP_CTRL_CYCLES - 1));

    // strobes live in the data phase, while hwdata stands;
    // read-only and unmapped offsets get none.
    // write strobes, one per register
    wire wCtrl = wrPend_ff & (wrAddr_ff == `GSP_OFS_CTRL);
    wire wUs = wrPend_ff & (wrAddr_ff == `GSP_OFS_USTHR);
    wire wSlW = wrPend_ff & (wrAddr_ff == `GSP_OFS_SLWORK);
    wire wSlS = wrPend_ff & (wrAddr_ff == `GSP_OFS_SLSTART);
    wire wOs = wrPend_ff & (wrAddr_ff == `GSP_OFS_OSTHR);
    wire wRat = wrPend_ff & (wrAddr_ff == `GSP_OFS_RATIO);
    wire wSct = wrPend_ff & (wrAddr_ff == `GSP_OFS_SCTIME);
    wire wExc = wrPend_ff & (wrAddr_ff == `GSP_OFS_EXCLO);

    // the jumper counts only while its enable bit is set;
    // the flag forces 60 Hz alone. the trimmer replaces the
    // parameter word rather than offsetting it.
    // mode and threshold source
    wire trimEn = ctrl_ff[`GSP_CTRL_TRIMEN];
    wire mode60 = (ctrl_ff[`GSP_CTRL_JMPEN] & jumper60)
        | ctrl_ff[`GSP_CTRL_FLAG60];
    wire [14:0] usParam = trimEn ? trimmerPos : usThr_ff;
    wire [15:0] usTrip = modeScale(usTrip50(usParam), mode60);
    wire [15:0] osTrip = modeScale(osTrip50(osThr_ff), mode60);

    // the lowest overspeed trip equals the highest underspeed
    // trip, so alarms 6 and 7 never stand together.
    // alarm conditions from the latest measurement
    wire underSpd = freqMeas < usTrip;
    wire overSpd = freqMeas > osTrip;
    wire excBad = (excMeas > `GSP_EXC_UPPER)
        | (excMeas < excLo_ff);

    // the full product fits in 47 bits, so nothing is lost
    // before the shift; the clamp keeps a steep slope from
    // wrapping the setpoint below zero.
    // volts-per-hertz drop; zero slope gives zero drop
    wire [14:0] slope = (phase_ff == gsp_pkg::GSP_START)
        ? slStart_ff : slWork_ff;
    wire [15:0] dF = underSpd ? 16'(usTrip - freqMeas) : 16'h0000;
    wire [47:0] dropW = (48'(nominalSet) * 48'(dF) * 48'(slope))
        >> `GSP_VF_SHIFT;
    wire [15:0] drop = (dropW > 48'(nominalSet))
        ? nominalSet : 16'(dropW);
    wire [15:0] scaled = 16'(nominalSet - drop);

    // the floor is a quarter of nominal on a phase feed and
    // rises with the supply ratio; it overrides the slope so
    // the regulator's own supply cannot collapse.
    // floor: keep auxiliary supply up, ratio widens it
    wire [47:0] floorW = (48'(nominalSet) * `GSP_MIN_FRAC
        * 48'(17'(`GSP_FULL) + 17'(ratio_ff))) >> 30;
    wire [15:0] floorV = (floorW > 48'(nominalSet))
        ? nominalSet : 16'(floorW);
    wire [15:0] nxt_setpt = (scaled < floorV)
        ? floorV : scaled;

    // alarms outside this block stay zero, so the ok bit
    // simply means none of the low byte is set.
    // alarm word, bit n-1 for alarm n
    logic [15:0] nxt_alarm;
    always_comb begin
        nxt_alarm = 16'h0000;
        nxt_alarm[`GSP_AL_SHORT] = shortCircuit;
        nxt_alarm[`GSP_AL_UNDERSPD] = underSpd;
        nxt_alarm[`GSP_AL_OVERSPD] = overSpd;
        nxt_alarm[`GSP_AL_UNDEREXC] = excBad;
        nxt_alarm[`GSP_AL_OK] = ~(|nxt_alarm[7:0]);
    end

    // only a reset brings the start slope back.
    // start slope is kept until frequency first tops the trip
    assign nxt_phase = (phase_ff == gsp_pkg::GSP_START)
        & ~underSpd ? gsp_pkg::GSP_RUN : phase_ff;

    // one pattern at a time; underspeed wins since it is the
    // alarm that is reshaping the setpoint.
    // flash pattern: alarm number, volts-per-hertz ahead
    wire [3:0] nxt_flash = underSpd ? 4'h6
        : shortCircuit ? 4'h4
        : overSpd ? 4'h7
        : excBad ? 4'h8 : 4'h0;

    // mask bit n-1 routes alarm n to the relay.
    // alarm output through software mask only; no regulation
    wire nxt_apo = |(nxt_alarm[7:0]
        & ctrl_ff[`GSP_CTRL_MASK_LSB +: 8]);

    // the tenths count saturates so a long short cannot wrap
    // under the limit; a zero limit never expires, which is
    // how blocking is switched off.
    // short-circuit timing
    wire tenthDone = (tenthCnt_ff == 32'(TENTH_CYCLES - 1));
    wire scExpire = shortCircuit & (scTime_ff != 8'h00)
        & (tenths_ff >= scTime_ff);

    // read data is captured in the address phase, so hrdata
    // comes from a flip-flop; reads have no side effects.
    // read mux, address phase
    logic [31:0] rdMux;
    always_comb begin
        unique case (haddr)
            `GSP_OFS_CTRL: rdMux = {16'h0000, ctrl_ff};
            `GSP_OFS_USTHR: rdMux = {17'h00000, usThr_ff};
            `GSP_OFS_SLWORK: rdMux = {17'h00000, slWork_ff};
            `GSP_OFS_SLSTART: rdMux = {17'h00000, slStart_ff};
            `GSP_OFS_OSTHR: rdMux = {16'h0000, osThr_ff};
            `GSP_OFS_RATIO: rdMux = {16'h0000, ratio_ff};
            `GSP_OFS_SCTIME: rdMux = {24'h000000, scTime_ff};
            `GSP_OFS_EXCLO: rdMux = {16'h0000, excLo_ff};
            `GSP_OFS_USEFF: rdMux = {17'h00000, usEff_ff};
            `GSP_OFS_ALARM: rdMux = {16'h0000, alarm_ff};
            `GSP_OFS_SETPT: rdMux = {16'h0000, setpt_ff};
            `GSP_OFS_TRIPS: rdMux = {osTripR_ff, usTripR_ff};
            default: rdMux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // one pending write per accepted write address phase.
    // bus phase tracking
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wrPend_ff <= wrAccept;
            if (wrAccept) begin
                wrAddr_ff <= haddr;
            end
            if (rdAccept) begin
                rdata_ff <= rdMux;
            end
        end
    end

    // a ctrl write and a parameter write cannot share a cycle,
    // as only one data phase is live at a time.
    // control register; threshold and working slope writes drop the trimmer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_ff <= `GSP_CTRL_RST;
        end else if (wCtrl) begin
            ctrl_ff <= hwdata[15:0];
        end else if (wUs | wSlW) begin
            ctrl_ff[`GSP_CTRL_TRIMEN] <= 1'b0;
        end
    end

    // parameter words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            usThr_ff <= `GSP_USTHR_RST;
            slWork_ff <= `GSP_SLWORK_RST;
            slStart_ff <= `GSP_SLSTART_RST;
            osThr_ff <= `GSP_OSTHR_RST;
            ratio_ff <= `GSP_RATIO_RST;
            scTime_ff <= `GSP_SCTIME_RST;
            excLo_ff <= `GSP_EXCLO_RST;
        end else begin
            if (wUs) usThr_ff <= hwdata[14:0];
            if (wSlW) slWork_ff <= hwdata[14:0];
            if (wSlS) slStart_ff <= hwdata[14:0];
            if (wOs) osThr_ff <= hwdata[15:0];
            if (wRat) ratio_ff <= hwdata[15:0];
            if (wSct) scTime_ff <= hwdata[7:0];
            if (wExc) excLo_ff <= hwdata[15:0];
        end
    end

    // free running; one tick per 250 clocks from reset.
    // control-cycle divider
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tickCnt_ff <= 12'h000;
        end else begin
            tickCnt_ff <= tick ? 12'h000 : 12'(tickCnt_ff + 12'h001);
        end
    end

    // setpoint, alarm word and flash move together on the
    // tick, so the voltage loop never sees them disagree.
    // once per control cycle: trips, alarms, setpoint
    always_ff @(posedge clk) begin
        if (!nrst) begin
            phase_ff <= gsp_pkg::GSP_START;
            usEff_ff <= `GSP_USTHR_RST;
            usTripR_ff <= 16'h0000;
            osTripR_ff <= 16'h0000;
            alarm_ff <= 16'h0800;
            setpt_ff <= 16'h0000;
            apo_ff <= 1'b0;
            flash_ff <= 4'h0;
        end else if (tick) begin
            phase_ff <= nxt_phase;
            usEff_ff <= usParam;
            usTripR_ff <= usTrip;
            osTripR_ff <= osTrip;
            alarm_ff <= nxt_alarm;
            setpt_ff <= nxt_setpt;
            apo_ff <= nxt_apo;
            flash_ff <= nxt_flash;
        end
    end

    // a short that clears resets the count; blocking stays.
    // short-circuit timer in tenths; block holds till reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tenthCnt_ff <= 32'h0000_0000;
            tenths_ff <= 8'h00;
            blocked_ff <= 1'b0;
        end else if (!shortCircuit) begin
            tenthCnt_ff <= 32'h0000_0000;
            tenths_ff <= 8'h00;
        end else begin
            tenthCnt_ff <= tenthDone ? 32'h0000_0000
                : tenthCnt_ff + 32'h0000_0001;
            if (tenthDone && tenths_ff != 8'hFF) begin
                tenths_ff <= tenths_ff + 8'h01;
            end
            if (scExpire) begin
                blocked_ff <= 1'b1;
            end
        end
    end

    // zero wait states, always an okay response.
    // outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_ff;
    assign setpointOut = setpt_ff;
    assign alarmOutput = apo_ff;
    assign blocked = blocked_ff;
    assign flashCode = flash_ff;

endmodule // gsp_speed_prot
